// ### smct_regs.svh
// Purpose: Register addresses, field positions, reset values and timing
//          figures for the sensor misc control and self-test block.
// Assumes: Byte addresses are the 7-bit frame address field.
// Notes:   Definitions only; included by smct_pkg, smct_top and smct_top_bench.
`ifndef SMCT_REGS_SVH
`define SMCT_REGS_SVH

// Byte addresses (low byte of each 16-bit register is the even one)
`define SMCT_A_AUX_LO    7'h30
`define SMCT_A_AUX_HI    7'h31
`define SMCT_A_GPIO_LO   7'h32
`define SMCT_A_MISC_LO   7'h34
`define SMCT_A_MISC_HI   7'h35
`define SMCT_A_PERIOD_LO 7'h36
`define SMCT_A_DIAG_LO   7'h3C
`define SMCT_A_GCMD_LO   7'h3E

// Reset values and writable masks
`define SMCT_MISC_RESET  16'h0006
`define SMCT_MISC_WMASK  16'h0FC7
`define SMCT_AUX_RESET   16'h0000
`define SMCT_PERIOD_RST  8'h01

// Field positions
`define SMCT_MISC_MEMTEST 11
`define SMCT_MISC_SELFTST 10
`define SMCT_MISC_STNEG   9
`define SMCT_MISC_STPOS   8
`define SMCT_MISC_GCOMP   7
`define SMCT_MISC_ORIGIN  6
`define SMCT_MISC_DR_EN   2
`define SMCT_MISC_DR_POL  1
`define SMCT_MISC_DR_SEL  0
`define SMCT_GCMD_LATCH   2
`define SMCT_GPIO_DIR3    2
`define SMCT_PERIOD_TB    7
`define SMCT_DIAG_CKSUM   6
`define SMCT_DIAG_STERR   5
`define SMCT_DIAG_ST_LSB  10
`define SMCT_FRAME_WR     15
`define SMCT_DAC_BITS     12

// Frame and flash geometry
`define SMCT_LAST_BIT    4'hF
`define SMCT_FLASH_AW    6
`define SMCT_FLASH_LAST  6'h3F

// Times in their own units and the core clock rate
`define SMCT_CLK_MHZ     100
`define SMCT_TB_FAST_MS  0.61035
`define SMCT_TB_SLOW_MS  18.921
`define SMCT_DRDY_MIN_US 100
`define SMCT_DRDY_MAX_US 200
`define SMCT_SELFTEST_US 50

`endif

// ### smct_pkg.sv
// Purpose: Shared types for the sensor misc control and self-test block.
// Assumes: Constants live in smct_regs.svh.
// Notes:   One-hot state codes are written out.
package smct_pkg;
	`include "smct_regs.svh"

	// Test sequencer states
	typedef enum logic [2:0]
	{
		SMCT_IDLE = 3'h1,
		SMCT_MEM  = 3'h2,
		SMCT_SELF = 3'h4
	} smct_state_t;
endpackage

// ### smct_top.sv
// Purpose: Misc control of an inertial sensor: data ready indicator, aux
//          DAC double buffer, self-test and flash checksum test, reached
//          by 16-bit serial frames.
// Assumes: Serial mode 3 (mosi sampled on sclk rise, miso on fall);
//          flash_data is valid for flash_addr in the same core cycle.
// Notes:   Serial logic runs on spi_sclk; frames cross by toggle.
// Behaviour
// - After reset misc control holds 0x0006, so data ready is on, active high, on line one.
// - Each data ready pulse lasts between 100 and 200 microseconds.
// - Misc control bit 2 enables data ready, bit 1 sets polarity, bit 0 picks line two over line one.
// - Writing 1 to bit 11 starts the memory test and the device clears the bit when done.
// - Writing 1 to bit 10 runs the automatic self-test, records per-sensor results and clears the bit.
// - Bit 9 applies the negative stimulus and bit 8 the positive one while set.
// - Bit 7 enables gyro bias compensation for acceleration and bit 6 accelerometer origin alignment.
// - The aux DAC register holds a 12-bit offset-binary code in its low bits, upper four unused.
// - Writing the aux DAC register leaves the output alone until the latch command copies it.
// - The memory test checksums the flash and sets diagnostic bit 6 on a failure; a pass leaves the bit as it was.
// - Global command bit 2 triggers the DAC latch and reads back 0 once the copy is done.
// - Reading the diagnostic flags clears them; a test result event in the same cycle sets them again.
`include "smct_regs.svh"
module smct_top
	import smct_pkg::*;
#(
	parameter int unsigned DRDY_CYCLES = `SMCT_DRDY_MIN_US * `SMCT_CLK_MHZ,
	parameter int unsigned TB_FAST_CYC =
		int'(`SMCT_TB_FAST_MS * 1000.0 * `SMCT_CLK_MHZ),
	parameter int unsigned TB_SLOW_CYC =
		int'(`SMCT_TB_SLOW_MS * 1000.0 * `SMCT_CLK_MHZ),
	parameter int unsigned SELF_CYCLES = `SMCT_SELFTEST_US * `SMCT_CLK_MHZ
)
(
	input  wire logic        core_clk,           // Core clock, 100 MHz
	input  wire logic        resetn,             // Async reset, active low
	input  wire logic        spi_sclk,           // Serial clock from host
	input  wire logic        spi_cs_n,           // Frame select, active low
	input  wire logic        spi_mosi,           // Serial data in
	output logic             spi_miso,           // Serial data out
	output logic             line_one_out,       // General line one level
	output logic             line_one_oe_n,      // Line one drive, low=on
	output logic             line_two_out,       // General line two level
	output logic             line_two_oe_n,      // Line two drive, low=on
	input  wire logic        line_three_in,      // External sample clock
	output logic [5:0]       flash_addr,         // Flash word address
	input  wire logic [15:0] flash_data,         // Flash word at address
	input  wire logic [5:0]  st_fail_in,         // Per-sensor test fails
	output logic             stim_pos,           // Positive stimulus on
	output logic             stim_neg,           // Negative stimulus on
	output logic             gyro_accel_comp,    // Gyro accel bias comp
	output logic             accel_origin_align, // Accel origin alignment
	output logic [11:0]      dac_value,          // DAC input register
	output logic             ext_clk_mode        // External sampling on
);

	// Place one byte into the low or high half of a 16-bit register
	function automatic logic [15:0] wr_byte(input logic [15:0] old,
		input logic [7:0] dat, input logic hi);
		wr_byte = hi ? {dat, old[7:0]} : {old[15:8], dat};
	endfunction

	// Serial domain state
	logic [3:0]  bit_cnt_q, bit_cnt_d;
	logic [14:0] sh_q, sh_d;
	logic [15:0] frame_q, frame_d;
	logic        tgl_q, tgl_d;
	logic        miso_q, miso_d;
	logic [15:0] rd_word_q, rd_word_d;

	// Shift in 16 bits; the last bit completes the frame
	always_comb
	begin
		bit_cnt_d = bit_cnt_q + 4'h1;
		sh_d      = {sh_q[13:0], spi_mosi};
		frame_d   = frame_q;
		tgl_d     = tgl_q;
		if (bit_cnt_q == `SMCT_LAST_BIT)
		begin
			frame_d = {sh_q, spi_mosi};
			tgl_d   = ~tgl_q;
		end
		// Read word is held still by the core for the whole frame
		miso_d = rd_word_q[`SMCT_LAST_BIT - bit_cnt_q];
	end

	// Bit count restarts whenever select goes high between frames; reset
	// too, so a select edge missed at power-up cannot leave it unknown
	always_ff @(posedge spi_sclk or posedge spi_cs_n or negedge resetn)
	begin
		if (!resetn)
			bit_cnt_q <= 4'h0;
		else if (spi_cs_n)
			bit_cnt_q <= 4'h0;
		else
			bit_cnt_q <= bit_cnt_d;
	end

	// Frame capture and completion toggle
	always_ff @(posedge spi_sclk or negedge resetn)
	begin
		if (!resetn)
		begin
			sh_q    <= 15'h0000;
			frame_q <= 16'h0000;
			tgl_q   <= 1'b0;
		end
		else
		begin
			sh_q    <= sh_d;
			frame_q <= frame_d;
			tgl_q   <= tgl_d;
		end
	end

	// Output bit changes on the falling edge for the host to sample
	always_ff @(negedge spi_sclk or negedge resetn)
	begin
		if (!resetn)
			miso_q <= 1'b0;
		else
			miso_q <= miso_d;
	end

	// Core domain state
	logic        tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic        l3_s1_q, l3_s2_q, l3_s3_q;
	logic [15:0] misc_q, misc_d;
	logic [15:0] aux_q, aux_d;
	logic [11:0] dac_q, dac_d;
	logic        latch_q, latch_d;
	logic [7:0]  gpio_q, gpio_d;
	logic [7:0]  period_q, period_d;
	logic [15:0] diag_q, diag_d;
	logic [31:0] tmr_q, tmr_d;
	logic [31:0] drdy_cnt_q, drdy_cnt_d;
	logic        drdy_q, drdy_d;
	logic [31:0] run_q, run_d;
	logic [5:0]  faddr_q, faddr_d;
	logic [15:0] fsum_q, fsum_d;
	smct_state_t state_q, state_d;
	logic        l1_out_q, l1_out_d, l1_oe_n_q, l1_oe_n_d;
	logic        l2_out_q, l2_out_d, l2_oe_n_q, l2_oe_n_d;
	logic        pos_q, pos_d, neg_q, neg_d, ext_q, ext_d;

	// Two-flop synchronisers; the third flop only serves edge detection
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
			l3_s1_q  <= 1'b0;
			l3_s2_q  <= 1'b0;
			l3_s3_q  <= 1'b0;
		end
		else
		begin
			tgl_s1_q <= tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
			l3_s1_q  <= line_three_in;
			l3_s2_q  <= l3_s1_q;
			l3_s3_q  <= l3_s2_q;
		end
	end

	logic        frame_ev;
	logic        is_wr;
	logic [6:0]  addr;
	logic [7:0]  dat;
	logic        ext_mode;
	logic        tick;
	logic [31:0] period_cyc;
	logic        dr_lvl;

	// Register file, sampling, data ready and test sequencing
	always_comb
	begin
		frame_ev   = tgl_s2_q ^ tgl_s3_q;
		is_wr      = frame_q[`SMCT_FRAME_WR];
		addr       = frame_q[14:8];
		dat        = frame_q[7:0];
		misc_d     = misc_q;
		aux_d      = aux_q;
		dac_d      = dac_q;
		latch_d    = latch_q;
		gpio_d     = gpio_q;
		period_d   = period_q;
		diag_d     = diag_q;
		rd_word_d  = rd_word_q;
		tmr_d      = tmr_q;
		drdy_cnt_d = drdy_cnt_q;
		drdy_d     = drdy_q;
		run_d      = run_q;
		faddr_d    = faddr_q;
		fsum_d     = fsum_q;
		state_d    = state_q;
		tick       = 1'b0;

		// Latch copies the whole stored code at once
		if (latch_q)
		begin
			dac_d   = aux_q[`SMCT_DAC_BITS-1:0];
			latch_d = 1'b0;
		end

		// Test sequencer; completion clears its start bit
		case (state_q)
			SMCT_IDLE:
			begin
				if (misc_q[`SMCT_MISC_MEMTEST])
				begin
					state_d = SMCT_MEM;
					faddr_d = 6'h00;
					fsum_d  = 16'h0000;
				end
				else if (misc_q[`SMCT_MISC_SELFTST])
				begin
					state_d = SMCT_SELF;
					run_d   = 32'h0000_0000;
				end
			end
			SMCT_MEM:
			begin
				// Last flash word holds the expected sum of the rest
				if (faddr_q == `SMCT_FLASH_LAST)
				begin
					misc_d[`SMCT_MISC_MEMTEST] = 1'b0;
					state_d = SMCT_IDLE;
				end
				else
				begin
					fsum_d  = fsum_q + flash_data;
					faddr_d = faddr_q + 6'h01;
				end
			end
			SMCT_SELF:
			begin
				run_d = run_q + 32'h0000_0001;
				if (run_q == SELF_CYCLES - 1)
				begin
					misc_d[`SMCT_MISC_SELFTST] = 1'b0;
					state_d = SMCT_IDLE;
				end
			end
			default:
				state_d = SMCT_IDLE;
		endcase

		// Frame decode; a host write lands after any completion clear
		if (frame_ev)
		begin
			if (is_wr)
			begin
				case (addr)
					`SMCT_A_AUX_LO, `SMCT_A_AUX_HI:
						aux_d = wr_byte(aux_q, dat, addr[0]);
					`SMCT_A_MISC_LO, `SMCT_A_MISC_HI:
						misc_d = wr_byte(misc_d, dat, addr[0])
							& `SMCT_MISC_WMASK;
					`SMCT_A_GCMD_LO:
						if (dat[`SMCT_GCMD_LATCH])
							latch_d = 1'b1;
					`SMCT_A_GPIO_LO:
						gpio_d = dat;
					`SMCT_A_PERIOD_LO:
						period_d = dat;
					default:
						rd_word_d = rd_word_q;
				endcase
			end
			else
			begin
				// Answer goes out in the following frame
				case ({addr[6:1], 1'b0})
					`SMCT_A_MISC_LO:   rd_word_d = misc_q;
					`SMCT_A_AUX_LO:    rd_word_d = aux_q;
					`SMCT_A_GCMD_LO:   rd_word_d = {13'h0000, latch_q, 2'h0};
					`SMCT_A_GPIO_LO:   rd_word_d = {8'h00, gpio_q};
					`SMCT_A_PERIOD_LO: rd_word_d = {8'h00, period_q};
					`SMCT_A_DIAG_LO:   rd_word_d = diag_q;
					default:           rd_word_d = 16'h0000;
				endcase
				if ({addr[6:1], 1'b0} == `SMCT_A_DIAG_LO)
					diag_d = 16'h0000;
			end
		end

		// Result events set flags after the read clear, so they win
		if (state_q == SMCT_MEM && faddr_q == `SMCT_FLASH_LAST
			&& flash_data != fsum_q)
			diag_d[`SMCT_DIAG_CKSUM] = 1'b1;
		if (state_q == SMCT_SELF && run_q == SELF_CYCLES - 1)
		begin
			diag_d[`SMCT_DIAG_ST_LSB+5:`SMCT_DIAG_ST_LSB] =
				diag_d[`SMCT_DIAG_ST_LSB+5:`SMCT_DIAG_ST_LSB]
				| st_fail_in;
			if (|st_fail_in)
				diag_d[`SMCT_DIAG_STERR] = 1'b1;
		end

		// Sample clock: external edges or period tB * (Ns + 1)
		ext_mode = !gpio_q[`SMCT_GPIO_DIR3] && period_q == 8'h00;
		period_cyc = 32'((period_q[`SMCT_PERIOD_TB] ? TB_SLOW_CYC
			: TB_FAST_CYC) * ({25'h0, period_q[6:0]} + 32'h1));
		if (ext_mode)
		begin
			tmr_d = 32'h0000_0000;
			tick  = l3_s2_q && !l3_s3_q;
		end
		else if (tmr_q >= period_cyc - 32'h1)
		begin
			tmr_d = 32'h0000_0000;
			tick  = 1'b1;
		end
		else
			tmr_d = tmr_q + 32'h0000_0001;

		// Pulse stands exactly DRDY_CYCLES core cycles
		if (tick)
		begin
			drdy_d     = 1'b1;
			drdy_cnt_d = DRDY_CYCLES - 1;
		end
		else if (drdy_cnt_q != 32'h0000_0000)
			drdy_cnt_d = drdy_cnt_q - 32'h0000_0001;
		else
			drdy_d = 1'b0;

		// Indicator drives only the selected line while enabled
		dr_lvl = drdy_q ? misc_q[`SMCT_MISC_DR_POL]
			: !misc_q[`SMCT_MISC_DR_POL];
		l1_out_d  = dr_lvl;
		l2_out_d  = dr_lvl;
		l1_oe_n_d = !(misc_q[`SMCT_MISC_DR_EN]
			&& !misc_q[`SMCT_MISC_DR_SEL]);
		l2_oe_n_d = !(misc_q[`SMCT_MISC_DR_EN]
			&& misc_q[`SMCT_MISC_DR_SEL]);

		// Stimulus: manual bits, plus positive drive during auto test
		pos_d = misc_q[`SMCT_MISC_STPOS] || state_q == SMCT_SELF;
		neg_d = misc_q[`SMCT_MISC_STNEG];
		ext_d = ext_mode;
	end

	// Core registers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			misc_q     <= `SMCT_MISC_RESET;
			aux_q      <= `SMCT_AUX_RESET;
			dac_q      <= 12'h000;
			latch_q    <= 1'b0;
			gpio_q     <= 8'h00;
			period_q   <= `SMCT_PERIOD_RST;
			diag_q     <= 16'h0000;
			rd_word_q  <= 16'h0000;
			tmr_q      <= 32'h0000_0000;
			drdy_cnt_q <= 32'h0000_0000;
			drdy_q     <= 1'b0;
			run_q      <= 32'h0000_0000;
			faddr_q    <= 6'h00;
			fsum_q     <= 16'h0000;
			state_q    <= SMCT_IDLE;
			l1_out_q   <= 1'b0;
			l1_oe_n_q  <= 1'b1;
			l2_out_q   <= 1'b0;
			l2_oe_n_q  <= 1'b1;
			pos_q      <= 1'b0;
			neg_q      <= 1'b0;
			ext_q      <= 1'b0;
		end
		else
		begin
			misc_q     <= misc_d;
			aux_q      <= aux_d;
			dac_q      <= dac_d;
			latch_q    <= latch_d;
			gpio_q     <= gpio_d;
			period_q   <= period_d;
			diag_q     <= diag_d;
			rd_word_q  <= rd_word_d;
			tmr_q      <= tmr_d;
			drdy_cnt_q <= drdy_cnt_d;
			drdy_q     <= drdy_d;
			run_q      <= run_d;
			faddr_q    <= faddr_d;
			fsum_q     <= fsum_d;
			state_q    <= state_d;
			l1_out_q   <= l1_out_d;
			l1_oe_n_q  <= l1_oe_n_d;
			l2_out_q   <= l2_out_d;
			l2_oe_n_q  <= l2_oe_n_d;
			pos_q      <= pos_d;
			neg_q      <= neg_d;
			ext_q      <= ext_d;
		end
	end

	// Outputs straight from flops
	assign spi_miso           = miso_q;
	assign line_one_out       = l1_out_q;
	assign line_one_oe_n      = l1_oe_n_q;
	assign line_two_out       = l2_out_q;
	assign line_two_oe_n      = l2_oe_n_q;
	assign flash_addr         = faddr_q;
	assign stim_pos           = pos_q;
	assign stim_neg           = neg_q;
	assign gyro_accel_comp    = misc_q[`SMCT_MISC_GCOMP];
	assign accel_origin_align = misc_q[`SMCT_MISC_ORIGIN];
	assign dac_value          = dac_q;
	assign ext_clk_mode       = ext_q;
endmodule

// ### smct_monitor.sv
// Purpose: Port assertions for the misc control and self-test block.
// Assumes: Everything is judged on the core clock; serial pins are async.
// Notes:   Bound to every smct_top instance at the foot of this file.
module smct_monitor
#(
	parameter int unsigned DRDY_CYCLES = 20,
	parameter int unsigned SELF_CYCLES = 50
)
(
	input wire logic        core_clk,           // Core clock
	input wire logic        resetn,             // Async reset, low
	input wire logic        spi_sclk,           // Serial clock
	input wire logic        spi_cs_n,           // Frame select
	input wire logic        spi_miso,           // Serial data out
	input wire logic        line_one_oe_n,      // Line one drive
	input wire logic        line_two_out,       // Line two level
	input wire logic        line_two_oe_n,      // Line two drive
	input wire logic [5:0]  flash_addr,         // Flash address
	input wire logic        stim_pos,           // Positive stimulus
	input wire logic        stim_neg,           // Negative stimulus
	input wire logic        gyro_accel_comp,    // Bias compensation
	input wire logic        accel_origin_align, // Origin alignment
	input wire logic [11:0] dac_value,          // DAC input register
	input wire logic        ext_clk_mode        // External sampling
);
	timeunit 1ns;
	timeprecision 100ps;

	logic        first_q, first_d;
	logic        seen_q,  seen_d;
	logic [15:0] hi_q,    hi_d;
	logic [15:0] st_q,    st_d;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// Run lengths; a pulse counts only after idle was seen while driven,
	// so a line switched on mid-pulse cannot give a short false run
	always_comb
	begin
		first_d = 1'b0;
		seen_d  = !line_two_oe_n && (seen_q || !line_two_out);
		hi_d    = line_two_out ? hi_q + 16'h0001 : 16'h0000;
		st_d    = stim_pos ? st_q + 16'h0001 : 16'h0000;
	end

	// Helper registers only
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			{first_q, seen_q, hi_q, st_q} <= {2'h2, 16'h0000, 16'h0000};
		else
			{first_q, seen_q, hi_q, st_q} <= {first_d, seen_d, hi_d, st_d};
	end

	sequence s_frame_start;
		$fell(spi_cs_n);
	endsequence

	a_one_line_only: assert property (line_one_oe_n || line_two_oe_n)
		else $error("both data ready lines driven");
	a_reset_state: assert property (first_q |-> ##1
		!line_one_oe_n && line_two_oe_n && !ext_clk_mode)
		else $error("wrong line setup after reset");
	a_dac_frame_quiet: assert property (s_frame_start |=>
		$stable(dac_value)[*8]) else $error("dac moved at frame start");
	a_ctrl_frame_quiet: assert property (s_frame_start |=>
		$stable({stim_neg, gyro_accel_comp, accel_origin_align,
		line_one_oe_n, line_two_oe_n, ext_clk_mode})[*8])
		else $error("control output moved at frame start");
	a_flash_walk: assert property ($changed(flash_addr) |->
		flash_addr == $past(flash_addr) + 6'h01 || flash_addr == 6'h00)
		else $error("flash address skipped");
	a_miso_on_fall: assert property ($changed(spi_miso) |->
		$fell(spi_sclk) || $changed(spi_cs_n))
		else $error("serial out moved off falling edge");
	a_dr_pulse_width: assert property ($fell(line_two_out) && seen_q
		&& !line_two_oe_n |-> hi_q == DRDY_CYCLES)
		else $error("data ready pulse width wrong");
	a_auto_stim_len: assert property ($fell(stim_pos) |->
		st_q >= SELF_CYCLES) else $error("stimulus too short");
endmodule

bind smct_top smct_monitor #(.DRDY_CYCLES(DRDY_CYCLES),
	.SELF_CYCLES(SELF_CYCLES)) i_smct_monitor (.core_clk, .resetn,
	.spi_sclk, .spi_cs_n, .spi_miso, .line_one_oe_n, .line_two_out,
	.line_two_oe_n, .flash_addr, .stim_pos, .stim_neg, .gyro_accel_comp,
	.accel_origin_align, .dac_value, .ext_clk_mode);

// ### smct_host.sv
// Purpose: Host processor model sending 16-bit serial frames.
// Assumes: Mode 3, serial clock idles high, 125 ns serial period.
// Notes:   Serial clock runs only inside frames; 1 us gap after each.
module smct_host
(
	output logic      spi_sclk, // Serial clock, idles high
	output logic      spi_cs_n, // Frame select, low active
	output logic      spi_mosi, // Data to device
	input  wire logic spi_miso  // Data from device
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus at time zero
	initial
	begin
		spi_sclk = 1'b1;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// One frame out, previous read word back, MSB first
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		spi_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			#62.5 spi_sclk = 1'b0;
			spi_mosi = w[i];
			#62.5 spi_sclk = 1'b1;
			r[i] = spi_miso;
		end
		#62.5 spi_cs_n = 1'b1;
		// Released line shows the inverse so a stale bit cannot pass
		spi_mosi = ~w[0];
		#1000;
	endtask
endmodule

// ### smct_top_bench.sv
// Purpose: Self-checking bench for the misc control and self-test block.
// Assumes: Shortened counts; the host model sends every frame.
// Notes:   Expected values come from the register map and fixed counts.
module smct_top_bench
	import smct_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	`include "smct_regs.svh"
	localparam int DRDY = 20;
	localparam int SELF = 50;
	localparam int SLOW = 300;
	logic        core_clk, resetn, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
	logic        line_one_out, line_one_oe_n, line_two_out, line_two_oe_n;
	logic        line_three_in, stim_pos, stim_neg, ext_clk_mode;
	logic        gyro_accel_comp, accel_origin_align;
	logic [5:0]  flash_addr, st_fail_in;
	logic [15:0] flash_data, fmem [64];
	logic [11:0] dac_value;
	int          num_errors = 0, n_compared = 0, cyc = 0;

	smct_top #(.DRDY_CYCLES(DRDY), .TB_FAST_CYC(100), .TB_SLOW_CYC(SLOW),
		.SELF_CYCLES(SELF)) i_smct_top (.core_clk, .resetn, .spi_sclk,
		.spi_cs_n, .spi_mosi, .spi_miso, .line_one_out, .line_one_oe_n,
		.line_two_out, .line_two_oe_n, .line_three_in, .flash_addr,
		.flash_data, .st_fail_in, .stim_pos, .stim_neg, .gyro_accel_comp,
		.accel_origin_align, .dac_value, .ext_clk_mode);
	smct_host i_smct_host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);

	// Flash is a plain lookup, valid in the same cycle
	assign flash_data = fmem[flash_addr];

	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic tick;
		@(posedge core_clk) #1;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		tick;
		i_smct_host.xfer({1'b1, a, d}, r);
	endtask

	// Read word comes back during the following frame
	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		tick;
		i_smct_host.xfer({1'b0, a, 8'h00}, v);
		i_smct_host.xfer(16'h0000, v);
	endtask

	// Cycles until the chosen line (0 one, 1 two) shows the level
	task automatic wait_one(input logic sel, input logic lvl, output int n);
		n = 0;
		while ((sel ? line_two_out : line_one_out) !== lvl && n < 3000)
		begin
			tick;
			n++;
		end
	endtask

	// Width of the next whole active phase on the chosen line
	task automatic pulse_one(input logic sel, input logic act, output int w);
		wait_one(sel, !act, w);
		wait_one(sel, act, w);
		wait_one(sel, !act, w);
	endtask

	task automatic t_reset;
		logic [15:0] v;
		chk("line one drive", 16'h0000, 16'(line_one_oe_n));
		chk("line two drive", 16'h0001, 16'(line_two_oe_n));
		rd(`SMCT_A_MISC_LO, v);
		chk("misc reset", 16'h0006, v);
		rd(`SMCT_A_AUX_LO, v);
		chk("aux reset", 16'h0000, v);
	endtask

	task automatic t_drdy;
		int w;
		pulse_one(1'b0, 1'b1, w);
		chk("high pulse", 16'(DRDY), 16'(w));
		wr(`SMCT_A_MISC_LO, 8'h04);
		pulse_one(1'b0, 1'b0, w);
		chk("low pulse", 16'(DRDY), 16'(w));
		wr(`SMCT_A_MISC_LO, 8'h07);
		chk("line two on", 16'h0000, 16'(line_two_oe_n));
		chk("line one off", 16'h0001, 16'(line_one_oe_n));
		pulse_one(1'b1, 1'b1, w);
		chk("line two pulse", 16'(DRDY), 16'(w));
		repeat (500) tick;
		wr(`SMCT_A_MISC_LO, 8'h02);
		chk("lines off", 16'h0003, 16'({line_one_oe_n, line_two_oe_n}));
		wr(`SMCT_A_MISC_LO, 8'h06);
	endtask

	task automatic t_dac;
		logic [15:0] v;
		wr(`SMCT_A_AUX_LO, 8'hD9);
		wr(`SMCT_A_AUX_HI, 8'h04);
		chk("dac held", 16'h0000, 16'(dac_value));
		rd(`SMCT_A_AUX_LO, v);
		chk("aux value", 16'h04D9, v);
		wr(`SMCT_A_GCMD_LO, 8'h04);
		chk("dac latched", 16'h04D9, 16'(dac_value));
		rd(`SMCT_A_GCMD_LO, v);
		chk("latch bit", 16'h0000, v & 16'h0004);
		wr(`SMCT_A_AUX_LO, 8'h00);
		chk("dac held again", 16'h04D9, 16'(dac_value));
		wr(`SMCT_A_GCMD_LO, 8'h04);
		chk("dac whole copy", 16'h0400, 16'(dac_value));
	endtask

	task automatic t_ctrl;
		logic [15:0] v;
		wr(`SMCT_A_MISC_HI, 8'h02);
		// Shortened settling wait before judging the stimulus
		repeat (50) tick;
		chk("neg stim", 16'h0002, 16'({stim_neg, stim_pos}));
		wr(`SMCT_A_MISC_HI, 8'h01);
		chk("pos stim", 16'h0001, 16'({stim_neg, stim_pos}));
		wr(`SMCT_A_MISC_HI, 8'h00);
		chk("stim off", 16'h0000, 16'({stim_neg, stim_pos}));
		wr(`SMCT_A_MISC_LO, 8'hFE);
		chk("comp on", 16'h0003, 16'({gyro_accel_comp, accel_origin_align}));
		rd(`SMCT_A_MISC_LO, v);
		chk("misc unused bits", 16'h00C6, v);
		wr(`SMCT_A_MISC_LO, 8'h06);
		chk("comp off", 16'h0000, 16'({gyro_accel_comp, accel_origin_align}));
	endtask

	task automatic t_mem;
		logic [15:0] s, v;
		s = 16'h0000;
		tick;
		for (int i = 0; i < 63; i++)
		begin
			fmem[i] = 16'(i * 16'h0123);
			s = s + fmem[i];
		end
		fmem[63] = s;
		wr(`SMCT_A_MISC_HI, 8'h08);
		rd(`SMCT_A_MISC_LO, v);
		chk("memtest cleared", 16'h0006, v);
		rd(`SMCT_A_DIAG_LO, v);
		chk("checksum pass", 16'h0000, v);
		chk("flash end", 16'h003F, 16'(flash_addr));
		tick;
		fmem[63] = ~s;
		wr(`SMCT_A_MISC_HI, 8'h08);
		rd(`SMCT_A_DIAG_LO, v);
		chk("checksum fail", 16'h0040, v);
		rd(`SMCT_A_DIAG_LO, v);
		chk("flags cleared", 16'h0000, v);
	endtask

	task automatic t_self;
		logic [15:0] v;
		tick;
		st_fail_in = 6'h05;
		wr(`SMCT_A_MISC_HI, 8'h04);
		rd(`SMCT_A_MISC_LO, v);
		chk("self test cleared", 16'h0006, v);
		rd(`SMCT_A_DIAG_LO, v);
		chk("self test flags", 16'h1420, v);
		tick;
		st_fail_in = 6'h00;
	endtask

	task automatic t_ext;
		int w;
		wr(`SMCT_A_GPIO_LO, 8'h00);
		wr(`SMCT_A_PERIOD_LO, 8'h00);
		chk("ext mode on", 16'h0001, 16'(ext_clk_mode));
		tick;
		line_three_in = 1'b1;
		pulse_one(1'b0, 1'b1, w);
		chk("ext pulse", 16'(DRDY), 16'(w));
		line_three_in = 1'b0;
		wr(`SMCT_A_GPIO_LO, 8'h04);
		chk("ext mode off", 16'h0000, 16'(ext_clk_mode));
		// Slow time base: gap between pulses is one slow period less width
		wr(`SMCT_A_PERIOD_LO, 8'h80);
		pulse_one(1'b0, 1'b1, w);
		wait_one(1'b0, 1'b1, w);
		chk("slow period gap", 16'(SLOW - DRDY), 16'(w));
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Main sequence
	initial
	begin
		resetn = 1'b0;
		line_three_in = 1'b0;
		st_fail_in = 6'h00;
		foreach (fmem[i])
			fmem[i] = 16'h0000;
		repeat (10) @(posedge core_clk);
		#1 resetn = 1'b1;
		repeat (4) tick;
		t_reset;
		t_drdy;
		t_dac;
		t_ctrl;
		t_mem;
		t_self;
		t_ext;
		results;
	end

	// A hang counts as a mismatch
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			num_errors++;
			results;
		end
	end
endmodule
